// file: hdl/sffr_framer.v
// Purpose: builds device-to-host frames and parses host-to-device frames
// Assumes: link layer moves whole dwords; CRC and scrambling live elsewhere
// Notes:   transmit field inputs must hold steady while o_tx_busy is high
`timescale 1ns/1ns
`include "sffr_defines.vh"
module sffr_framer (
  input  wire        i_core_clk,
  input  wire        i_arst_n,
  // receive link side
  input  wire        i_rx_valid,
  input  wire [31:0] i_rx_data,
  input  wire        i_rx_last,
  output wire        o_rx_ready,
  // received payload to the data path
  output wire        o_rx_pay_valid,
  output wire [31:0] o_rx_pay_data,
  output wire        o_rx_pay_last,
  input  wire        i_rx_pay_ready,
  output reg         o_rx_bad,
  // decoded host command
  output reg         o_cmd_valid,
  output reg  [7:0]  o_cmd_code,
  output reg  [15:0] o_cmd_features,
  output reg         o_cmd_update,
  output reg  [7:0]  o_cmd_device,
  output reg  [47:0] o_cmd_lba,
  output reg  [15:0] o_cmd_count,
  output reg  [7:0]  o_cmd_control,
  output wire        o_cmd_linear,
  input  wire        i_cmd_ext,
  output wire [16:0] o_cmd_sectors,
  // transmit request
  input  wire        i_tx_req,
  input  wire [2:0]  i_tx_kind,
  output reg         o_tx_ack,
  output wire        o_tx_busy,
  input  wire [7:0]  i_tx_status,
  input  wire [7:0]  i_tx_error,
  input  wire [7:0]  i_tx_end_status,
  input  wire [7:0]  i_tx_device,
  input  wire [47:0] i_tx_lba,
  input  wire [15:0] i_tx_count,
  input  wire [15:0] i_tx_xfer_count,
  input  wire        i_tx_irq,
  input  wire        i_tx_dir,
  input  wire [4:0]  i_tx_tag,
  input  wire [31:0] i_tx_dma_offset,
  input  wire [31:0] i_tx_dma_count,
  input  wire [31:0] i_tx_done_tags,
  // transmit payload source
  input  wire        i_tx_pay_valid,
  input  wire [31:0] i_tx_pay_data,
  input  wire        i_tx_pay_last,
  output wire        o_tx_pay_ready,
  output reg         o_tx_len_err,
  // transmit link side
  output wire        o_tx_valid,
  output wire [31:0] o_tx_data,
  output wire        o_tx_last,
  input  wire        i_tx_ready,
  // shared power-segment pin
  input  wire        i_activity,
  input  wire        i_act_pin_i,
  output wire        o_act_pin_o,
  output wire        o_act_pin_oe,
  output reg         o_spinup_disabled
);
  localparam RX_IDLE = 2'h0;
  localparam RX_REG  = 2'h1;
  localparam RX_PAY  = 2'h2;
  localparam RX_SKIP = 2'h3;
  localparam TX_IDLE = 2'h0;
  localparam TX_HDR  = 2'h1;
  localparam TX_PAY  = 2'h2;

  function [2:0] last_idx;
    input [2:0] kind;
    begin
      case (kind)
        `SFFR_KIND_D2H:     last_idx = 3'h4;
        `SFFR_KIND_PIO:     last_idx = 3'h4;
        `SFFR_KIND_DMA_SET: last_idx = 3'h6;
        `SFFR_KIND_SDB:     last_idx = 3'h1;
        default:            last_idx = 3'h0;
      endcase
    end
  endfunction

  function [16:0] sector_total;
    input [15:0] count;
    input        ext;
    begin
      if (count != 16'h0000) begin
        sector_total = {1'b0, count};
      end else if (ext) begin
        sector_total = `SFFR_SECT_48;
      end else begin
        sector_total = `SFFR_SECT_28;
      end
    end
  endfunction

  // ==================================================
  // receive parser
  reg  [1:0]  rx_state;
  reg  [2:0]  rx_idx;
  reg  [11:0] rx_pay_cnt;
  wire        rx_buf_ready;
  wire        rx_take;
  wire        rx_pay_push;
  wire [11:0] rx_cnt_next;

  assign o_rx_ready    = (rx_state == RX_PAY) ? rx_buf_ready : 1'b1;
  assign rx_take       = i_rx_valid && o_rx_ready;
  assign rx_pay_push   = i_rx_valid && (rx_state == RX_PAY);
  assign rx_cnt_next   = (rx_pay_cnt == 12'hFFF) ? rx_pay_cnt : rx_pay_cnt + 12'h001;
  assign o_cmd_linear  = o_cmd_device[`SFFR_LBA_MODE_BIT];
  assign o_cmd_sectors = sector_total(o_cmd_count, i_cmd_ext);

  always @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rx_state       <= RX_IDLE;
      rx_idx         <= 3'h0;
      rx_pay_cnt     <= 12'h000;
      o_rx_bad       <= 1'b0;
      o_cmd_valid    <= 1'b0;
      o_cmd_code     <= 8'h00;
      o_cmd_features <= 16'h0000;
      o_cmd_update   <= 1'b0;
      o_cmd_device   <= 8'h00;
      o_cmd_lba      <= 48'h000000000000;
      o_cmd_count    <= 16'h0000;
      o_cmd_control  <= 8'h00;
    end else begin
      o_rx_bad    <= 1'b0;
      o_cmd_valid <= 1'b0;
      if (rx_take) begin
        case (rx_state)
          RX_IDLE: begin
            rx_idx     <= 3'h1;
            rx_pay_cnt <= 12'h000;
            if (i_rx_data[7:0] == `SFFR_TYPE_H2D_REG) begin
              o_cmd_code          <= i_rx_data[23:16];
              o_cmd_features[7:0] <= i_rx_data[31:24];
              o_cmd_update        <= i_rx_data[`SFFR_UPDATE_BIT];
              o_rx_bad            <= i_rx_last;
              rx_state            <= i_rx_last ? RX_IDLE : RX_REG;
            end else if (i_rx_data[7:0] == `SFFR_TYPE_DATA) begin
              o_rx_bad <= i_rx_last;
              rx_state <= i_rx_last ? RX_IDLE : RX_PAY;
            end else begin
              rx_state <= i_rx_last ? RX_IDLE : RX_SKIP;
            end
          end
          RX_REG: begin
            case (rx_idx)
              3'h1: begin
                o_cmd_device     <= i_rx_data[31:24];
                o_cmd_lba[23:0]  <= i_rx_data[23:0];
              end
              3'h2: begin
                o_cmd_features[15:8] <= i_rx_data[31:24];
                o_cmd_lba[47:24]     <= i_rx_data[23:0];
              end
              3'h3: begin
                o_cmd_control <= i_rx_data[31:24];
                o_cmd_count   <= i_rx_data[15:0];
              end
              default: begin
                o_cmd_control <= o_cmd_control;
              end
            endcase
            if (rx_idx != 3'h7) begin
              rx_idx <= rx_idx + 3'h1;
            end
            if (i_rx_last) begin
              rx_state    <= RX_IDLE;
              o_cmd_valid <= (rx_idx == `SFFR_REG_LAST_IDX);
              o_rx_bad    <= (rx_idx != `SFFR_REG_LAST_IDX);
            end
          end
          RX_PAY: begin
            rx_pay_cnt <= rx_cnt_next;
            if (i_rx_last) begin
              rx_state <= RX_IDLE;
              o_rx_bad <= (rx_cnt_next > `SFFR_PAY_MAX);
            end
          end
          default: begin
            if (i_rx_last) begin
              rx_state <= RX_IDLE;
            end
          end
        endcase
      end
    end
  end

  sffr_pair_buf u_rx_buf (
    .i_core_clk  (i_core_clk),
    .i_arst_n    (i_arst_n),
    .i_in_valid  (rx_pay_push),
    .i_in_data   ({i_rx_last, i_rx_data}),
    .o_in_ready  (rx_buf_ready),
    .o_out_valid (o_rx_pay_valid),
    .o_out_data  ({o_rx_pay_last, o_rx_pay_data}),
    .i_out_ready (i_rx_pay_ready)
  );

  // ==================================================
  // transmit builder
  reg  [1:0]  tx_state;
  reg  [2:0]  tx_kind;
  reg  [2:0]  tx_idx;
  reg  [11:0] tx_pay_cnt;
  reg  [31:0] hdr_word;
  wire        tx_buf_ready;
  wire        hdr_push;
  wire        hdr_last;
  wire        pay_push;
  wire        pay_cap;
  wire        in_valid;
  wire [32:0] in_data;

  assign o_tx_busy      = (tx_state != TX_IDLE);
  assign hdr_push       = (tx_state == TX_HDR) && tx_buf_ready;
  assign hdr_last       = (tx_idx == last_idx(tx_kind)) && (tx_kind != `SFFR_KIND_DATA);
  assign o_tx_pay_ready = (tx_state == TX_PAY) && tx_buf_ready;
  assign pay_push       = i_tx_pay_valid && o_tx_pay_ready;
  // cap the payload so an overlong source cannot emit a malformed frame
  assign pay_cap        = (tx_pay_cnt == `SFFR_PAY_MAX - 12'h001);
  assign in_valid       = (tx_state == TX_HDR) || ((tx_state == TX_PAY) && i_tx_pay_valid);
  assign in_data        = (tx_state == TX_HDR) ? {hdr_last, hdr_word}
                          : {i_tx_pay_last || pay_cap, i_tx_pay_data};

  // all unlisted bits stay zero
  always @* begin
    hdr_word = 32'h00000000;
    case (tx_kind)
      `SFFR_KIND_D2H: begin
        case (tx_idx)
          3'h0: hdr_word = {i_tx_error, i_tx_status, 1'b0, i_tx_irq, 6'h00, `SFFR_TYPE_D2H_REG};
          3'h1: hdr_word = {i_tx_device, i_tx_lba[23:0]};
          3'h2: hdr_word = {8'h00, i_tx_lba[47:24]};
          3'h3: hdr_word = {16'h0000, i_tx_count};
          default: hdr_word = 32'h00000000;
        endcase
      end
      `SFFR_KIND_PIO: begin
        case (tx_idx)
          3'h0: hdr_word = {i_tx_error, i_tx_status, 1'b0, i_tx_irq, i_tx_dir, 5'h00,
                            `SFFR_TYPE_PIO};
          3'h1: hdr_word = {i_tx_device, i_tx_lba[23:0]};
          3'h2: hdr_word = i_tx_device[`SFFR_LBA_MODE_BIT] ? {8'h00, i_tx_lba[47:24]}
                           : 32'h00000000;
          3'h3: hdr_word = {i_tx_end_status, 8'h00, i_tx_count};
          3'h4: hdr_word = {16'h0000, i_tx_xfer_count};
          default: hdr_word = 32'h00000000;
        endcase
      end
      `SFFR_KIND_DMA_ACT: begin
        hdr_word = {24'h000000, `SFFR_TYPE_DMA_ACT};
      end
      `SFFR_KIND_DMA_SET: begin
        case (tx_idx)
          3'h0: hdr_word = {16'h0000, 1'b0, i_tx_irq, i_tx_dir, 5'h00, `SFFR_TYPE_DMA_SET};
          3'h1: hdr_word = {27'h0000000, i_tx_tag};
          3'h4: hdr_word = i_tx_dma_offset;
          3'h5: hdr_word = i_tx_dma_count;
          default: hdr_word = 32'h00000000;
        endcase
      end
      `SFFR_KIND_SDB: begin
        if (tx_idx == 3'h0) begin
          hdr_word = {i_tx_error, i_tx_status, 1'b0, i_tx_irq, 6'h00, `SFFR_TYPE_SDB};
        end else begin
          hdr_word = i_tx_done_tags;
        end
      end
      `SFFR_KIND_DATA: begin
        hdr_word = {24'h000000, `SFFR_TYPE_DATA};
      end
      default: begin
        hdr_word = 32'h00000000;
      end
    endcase
  end

  always @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      tx_state     <= TX_IDLE;
      tx_kind      <= `SFFR_KIND_D2H;
      tx_idx       <= 3'h0;
      tx_pay_cnt   <= 12'h000;
      o_tx_ack     <= 1'b0;
      o_tx_len_err <= 1'b0;
    end else begin
      o_tx_ack     <= 1'b0;
      o_tx_len_err <= 1'b0;
      case (tx_state)
        TX_IDLE: begin
          if (i_tx_req && (i_tx_kind <= `SFFR_KIND_DATA)) begin
            tx_kind    <= i_tx_kind;
            tx_idx     <= 3'h0;
            tx_pay_cnt <= 12'h000;
            o_tx_ack   <= 1'b1;
            tx_state   <= TX_HDR;
          end
        end
        TX_HDR: begin
          if (hdr_push) begin
            tx_idx <= tx_idx + 3'h1;
            if (tx_kind == `SFFR_KIND_DATA) begin
              tx_state <= TX_PAY;
            end else if (hdr_last) begin
              tx_state <= TX_IDLE;
            end
          end
        end
        TX_PAY: begin
          if (pay_push) begin
            tx_pay_cnt <= tx_pay_cnt + 12'h001;
            if (i_tx_pay_last || pay_cap) begin
              tx_state     <= TX_IDLE;
              o_tx_len_err <= pay_cap && !i_tx_pay_last;
            end
          end
        end
        default: begin
          tx_state <= TX_IDLE;
        end
      endcase
    end
  end

  sffr_pair_buf u_tx_buf (
    .i_core_clk  (i_core_clk),
    .i_arst_n    (i_arst_n),
    .i_in_valid  (in_valid),
    .i_in_data   (in_data),
    .o_in_ready  (tx_buf_ready),
    .o_out_valid (o_tx_valid),
    .o_out_data  ({o_tx_last, o_tx_data}),
    .i_out_ready (i_tx_ready)
  );

  // ==================================================
  // shared power-segment pin
  reg strap_done;

  // open drain: pulled low while active, released otherwise
  assign o_act_pin_o  = 1'b0;
  assign o_act_pin_oe = i_activity && strap_done;

  // strap is caught on the first clock after reset, before any drive
  always @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      strap_done        <= 1'b0;
      o_spinup_disabled <= 1'b0;
    end else if (!strap_done) begin
      strap_done        <= 1'b1;
      o_spinup_disabled <= !i_act_pin_i;
    end
  end
endmodule

// file: pkg/sffr_defines.vh
// Purpose: constants for the frame information structure framer
// Assumes: dwords carry byte 0 in bits 7:0; one 100 MHz core clock
// Notes:   included by bare name from hdl/ files
//
// Behaviour
// - host register frame: type 27h, command 23:16, features 31:24, update bit 15.
// - 48-bit form: dwords 1..3 carry address, expanded bytes, counts; dword 4 zero.
// - data frame header is type 48h in low byte, rest zero, payload follows.
// - data payload holds 1 to 2048 dwords; otherwise the frame is malformed.
// - PIO setup: 34h, status, error, ending status, counts, transfer count dword 4.
// - geometry PIO setup: dword 1 device/head and cylinder/sector bytes, dword 2 zero.
// - DMA activate is one dword, type 39h, all other bits zero.
// - queued first-party DMA commands get a DMA setup frame for the chosen tag.
// - queued first-party DMA results are reported with a set-device-bits frame.
// - shared power pin: device shows activity; host may signal spin-up disable.
// - device byte bit 6 set selects linear addressing, clear selects geometry.
// - zero sector count means 256 (28-bit) or 65,536 (48-bit) sectors.
`ifndef SFFR_DEFINES_VH
`define SFFR_DEFINES_VH

// ==================================================
// frame type codes
`define SFFR_TYPE_H2D_REG  8'h27
`define SFFR_TYPE_D2H_REG  8'h34
`define SFFR_TYPE_PIO      8'h34
`define SFFR_TYPE_DMA_ACT  8'h39
`define SFFR_TYPE_DMA_SET  8'h41
`define SFFR_TYPE_SDB      8'hA1
`define SFFR_TYPE_DATA     8'h48

// ==================================================
// field positions
`define SFFR_UPDATE_BIT    15
`define SFFR_IRQ_BIT       14
`define SFFR_DIR_BIT       13
`define SFFR_LBA_MODE_BIT  6

// ==================================================
// transmit frame kinds
`define SFFR_KIND_D2H      3'h0
`define SFFR_KIND_PIO      3'h1
`define SFFR_KIND_DMA_ACT  3'h2
`define SFFR_KIND_DMA_SET  3'h3
`define SFFR_KIND_SDB      3'h4
`define SFFR_KIND_DATA     3'h5

// ==================================================
// sizes and counts
`define SFFR_REG_LAST_IDX  3'h4
`define SFFR_PAY_MAX       12'h800
`define SFFR_SECT_28       17'h00100
`define SFFR_SECT_48       17'h10000

`endif

// file: hdl/sffr_pair_buf.v
// Purpose: two-entry buffer with valid/ready on both sides
// Assumes: single clock, asynchronous active-low reset
// Notes:   full registered outputs; a stall downstream loses no word
`timescale 1ns/1ns
module sffr_pair_buf (
  input  wire        i_core_clk,
  input  wire        i_arst_n,
  input  wire        i_in_valid,
  input  wire [32:0] i_in_data,
  output wire        o_in_ready,
  output wire        o_out_valid,
  output wire [32:0] o_out_data,
  input  wire        i_out_ready
);
  reg [32:0] slot0;
  reg [32:0] slot1;
  reg [1:0]  fill;
  wire       push;
  wire       pop;

  assign o_in_ready  = (fill != 2'h2);
  assign o_out_valid = (fill != 2'h0);
  assign o_out_data  = slot0;
  assign push        = i_in_valid && o_in_ready;
  assign pop         = o_out_valid && i_out_ready;

  always @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      slot0 <= 33'h000000000;
      slot1 <= 33'h000000000;
      fill  <= 2'h0;
    end else begin
      case ({push, pop})
        2'b10: begin
          if (fill == 2'h0) begin
            slot0 <= i_in_data;
          end else begin
            slot1 <= i_in_data;
          end
          fill <= fill + 2'h1;
        end
        2'b01: begin
          slot0 <= slot1;
          fill  <= fill - 2'h1;
        end
        2'b11: begin
          if (fill == 2'h1) begin
            slot0 <= i_in_data;
          end else begin
            slot0 <= slot1;
            slot1 <= i_in_data;
          end
        end
        default: begin
          fill <= fill;
        end
      endcase
    end
  end
endmodule

// file: test/sffr_framer_sva.sv
// Purpose: port-level checker for the frame builder and parser
// Assumes: one core clock, asynchronous active-low reset
// Notes:   attached by bind at the foot of this file
`timescale 1ns/1ns
module sffr_framer_sva (
  input wire logic        i_core_clk,
  input wire logic        i_arst_n,
  input wire logic        i_tx_req,
  input wire logic [2:0]  i_tx_kind,
  input wire logic        o_tx_busy,
  input wire logic        o_tx_ack,
  input wire logic        o_tx_valid,
  input wire logic [31:0] o_tx_data,
  input wire logic        o_tx_last,
  input wire logic        i_tx_ready,
  input wire logic        o_rx_pay_valid,
  input wire logic [31:0] o_rx_pay_data,
  input wire logic        i_rx_pay_ready,
  input wire logic        o_cmd_valid,
  input wire logic        o_rx_bad,
  input wire logic [15:0] o_cmd_count,
  input wire logic        i_cmd_ext,
  input wire logic [16:0] o_cmd_sectors,
  input wire logic        o_cmd_linear,
  input wire logic [7:0]  o_cmd_device,
  input wire logic        o_act_pin_oe,
  input wire logic        o_act_pin_o
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_arst_n);
  // ==================================================
  // transmit and receive handshakes
  a_ack_after_req: assert property (i_tx_req && !o_tx_busy && i_tx_kind <= 3'h5 |=> o_tx_ack)
    else $error("request taken without acknowledge");
  a_tx_word_held: assert property (o_tx_valid && !i_tx_ready |=> o_tx_valid && $stable(o_tx_data) && $stable(o_tx_last))
    else $error("stalled transmit word changed");
  a_pay_word_held: assert property (o_rx_pay_valid && !i_rx_pay_ready |=> o_rx_pay_valid && $stable(o_rx_pay_data))
    else $error("stalled payload word changed");
  // five dwords make a command frame, so pulses are at least five apart
  a_cmd_pulse_apart: assert property (o_cmd_valid |=> !o_cmd_valid [*4])
    else $error("command pulses too close");
  a_bad_not_cmd: assert property (o_rx_bad |-> !o_cmd_valid)
    else $error("malformed frame reported as command");
  // ==================================================
  // decoded fields and pin
  a_sect_zero_short: assert property (o_cmd_count == 16'h0000 && !i_cmd_ext |-> o_cmd_sectors == 17'h00100)
    else $error("zero count not 256");
  a_sect_zero_long: assert property (o_cmd_count == 16'h0000 && i_cmd_ext |-> o_cmd_sectors == 17'h10000)
    else $error("zero count not 65536");
  a_sect_plain: assert property (o_cmd_count != 16'h0000 |-> o_cmd_sectors == {1'h0, o_cmd_count})
    else $error("sector count mismatch");
  a_linear_mode: assert property (o_cmd_linear == o_cmd_device[6])
    else $error("address mode bit wrong");
  a_pin_pull_low: assert property (o_act_pin_oe |-> !o_act_pin_o)
    else $error("pin driven high");
endmodule
bind sffr_framer sffr_framer_sva chk (.i_core_clk(i_core_clk), .i_arst_n(i_arst_n),
  .i_tx_req(i_tx_req), .i_tx_kind(i_tx_kind), .o_tx_busy(o_tx_busy), .o_tx_ack(o_tx_ack),
  .o_tx_valid(o_tx_valid), .o_tx_data(o_tx_data), .o_tx_last(o_tx_last),
  .i_tx_ready(i_tx_ready), .o_rx_pay_valid(o_rx_pay_valid), .o_rx_pay_data(o_rx_pay_data),
  .i_rx_pay_ready(i_rx_pay_ready), .o_cmd_valid(o_cmd_valid), .o_rx_bad(o_rx_bad),
  .o_cmd_count(o_cmd_count), .i_cmd_ext(i_cmd_ext), .o_cmd_sectors(o_cmd_sectors),
  .o_cmd_linear(o_cmd_linear), .o_cmd_device(o_cmd_device), .o_act_pin_oe(o_act_pin_oe),
  .o_act_pin_o(o_act_pin_o));

// file: test/sffr_host_model.sv
// Purpose: host controller side of the link, dword level
// Assumes: sender changes signals 1 ns after the clock edge
// Notes:   sink stalls one cycle in three to exercise the buffer
`timescale 1ns/1ns
module sffr_host_model (
  input  wire logic        i_core_clk,
  output logic             o_rx_valid,
  output logic [31:0]      o_rx_data,
  output logic             o_rx_last,
  input  wire logic        i_rx_ready,
  input  wire logic        i_tx_valid,
  input  wire logic [31:0] i_tx_data,
  input  wire logic        i_tx_last,
  output wire logic        o_tx_ready
);
  logic [32:0] got[$];
  logic [1:0]  ph;
  initial begin
    {o_rx_valid, o_rx_data, o_rx_last, ph} = 0;
  end
  assign o_tx_ready = (ph != 2'h0);
  always @(posedge i_core_clk) begin
    if (o_tx_ready && i_tx_valid) got.push_back({i_tx_last, i_tx_data});
    ph <= #1 (ph == 2'h2) ? 2'h0 : ph + 2'h1;
  end
  // byte 0 of each dword goes in bits 7:0
  task send(input logic [31:0] d, input logic l);
    o_rx_valid = 1;
    o_rx_data  = d;
    o_rx_last  = l;
    @(posedge i_core_clk);
    while (!i_rx_ready) @(posedge i_core_clk);
    #1;
  endtask
  // released bus shows the inverse so stale data is never mistaken
  task idle;
    o_rx_valid = 0;
    o_rx_data  = ~o_rx_data;
  endtask
endmodule

// file: test/testbench.sv
// Purpose: self-checking bench for the frame builder and parser
// Assumes: host model on the link, bench drives the device side
// Notes:   pulses are counted by watchers so no edge is missed
`timescale 1ns/1ns
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin mismatches++; \
  $display("BAD %0t %h expected %h", $time, a, b); end end
module testbench;
  logic clk, arst_n, pay_rdy, ext, req, act, host_pull, pv, pl;
  logic [2:0] kind;
  logic [31:0] pd;
  logic [7:0]  tdev;
  logic [47:0] tlba;
  logic [15:0] tcnt, txfer;
  logic        tirq, tdir;
  logic [4:0]  ttag;
  logic [31:0] tdone;
  logic [32:0] pay[$];
  int mismatches, tests_run, ncmd, nbad, nlen, cyc;
  wire rv, rl, rr, tv, tl, tr, prv, prl, ppr, cmdv, bad, oe, po, ack, busy, lerr;
  wire [31:0] rd, td, prd;
  wire pin = !(oe || host_pull);
  sffr_framer uut (.i_core_clk(clk), .i_arst_n(arst_n), .i_rx_valid(rv), .i_rx_data(rd),
    .i_rx_last(rl), .o_rx_ready(rr), .o_rx_pay_valid(prv), .o_rx_pay_data(prd),
    .o_rx_pay_last(prl), .i_rx_pay_ready(pay_rdy), .o_rx_bad(bad), .o_cmd_valid(cmdv),
    .o_cmd_code(), .o_cmd_features(), .o_cmd_update(), .o_cmd_device(), .o_cmd_lba(),
    .o_cmd_count(), .o_cmd_control(), .o_cmd_linear(), .i_cmd_ext(ext), .o_cmd_sectors(),
    .i_tx_req(req), .i_tx_kind(kind), .o_tx_ack(ack), .o_tx_busy(busy),
    .i_tx_status(8'h58), .i_tx_error(8'h04), .i_tx_end_status(8'h50), .i_tx_device(tdev),
    .i_tx_lba(tlba), .i_tx_count(tcnt), .i_tx_xfer_count(txfer),
    .i_tx_irq(tirq), .i_tx_dir(tdir), .i_tx_tag(ttag), .i_tx_dma_offset(32'h00000400),
    .i_tx_dma_count(32'h00001000), .i_tx_done_tags(tdone), .i_tx_pay_valid(pv),
    .i_tx_pay_data(pd), .i_tx_pay_last(pl), .o_tx_pay_ready(ppr), .o_tx_len_err(lerr),
    .o_tx_valid(tv), .o_tx_data(td), .o_tx_last(tl), .i_tx_ready(tr), .i_activity(act),
    .i_act_pin_i(pin), .o_act_pin_o(po), .o_act_pin_oe(oe), .o_spinup_disabled());
  sffr_host_model m (.i_core_clk(clk), .o_rx_valid(rv), .o_rx_data(rd), .o_rx_last(rl),
    .i_rx_ready(rr), .i_tx_valid(tv), .i_tx_data(td), .i_tx_last(tl), .o_tx_ready(tr));
  initial begin
    clk = 0;
    forever #5 clk = ~clk;
  end
  // ==================================================
  // watchers and timeout
  always @(posedge clk) begin
    ncmd += cmdv;
    nbad += bad;
    nlen += lerr;
    if (prv && pay_rdy) pay.push_back({prl, prd});
    pay_rdy <= #1 ~pay_rdy;
    cyc++;
    if (cyc == 30000) begin
      mismatches++;
      conclude;
    end
  end
  task conclude;
    $display("counts: %0d compared, %0d mismatched", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task tx_run(input logic [2:0] k, input int n);
    int i;
    m.got.delete();
    kind = k;
    req  = 1;
    for (i = 0; i < 20 && !ack; i++) @(posedge clk);
    #1 req = 0;
    for (i = 0; i < 4000 && m.got.size() < n; i++) @(posedge clk);
    #1 `CHK(m.got.size(), n)
    `CHK(m.got[n-1][32], 1'h1)
  endtask
  // ==================================================
  // scenarios
  task t_host_cmd;
    m.send(32'h11258027, 0); m.send(32'h40030201, 0); m.send(32'h22060504, 0);
    m.send(32'h08000000, 0); m.send(32'h00000000, 1); m.idle;
    repeat (2) @(posedge clk);
    #1 `CHK(ncmd, 1)
    `CHK(uut.o_cmd_code, 8'h25)
    `CHK(uut.o_cmd_features, 16'h2211)
    `CHK(uut.o_cmd_update, 1'h1)
    `CHK(uut.o_cmd_lba, 48'h060504030201)
    `CHK(uut.o_cmd_control, 8'h08)
    `CHK(uut.o_cmd_linear, 1'h1)
    `CHK(uut.o_cmd_sectors, 17'h10000)
    ext = 0;
    #1 `CHK(uut.o_cmd_sectors, 17'h00100)
    m.send(32'h00008027, 0); m.send(32'h0, 0); m.send(32'h0, 0); m.send(32'h0, 1); m.idle;
    repeat (2) @(posedge clk);
    #1 `CHK(nbad, 1)
    `CHK(ncmd, 1)
    $display("host command frames done");
  endtask
  task t_rx_data;
    int i, j;
    m.send(32'h00000048, 0); m.send(32'hA5A50001, 0); m.send(32'hA5A50002, 0);
    m.send(32'hA5A50003, 1); m.send(32'h00000048, 1); m.idle;
    for (i = 0; i < 50 && pay.size() < 3; i++) @(posedge clk);
    #1 `CHK(pay.size(), 3)
    `CHK(pay[0], 33'h0A5A50001)
    `CHK(pay[2], 33'h1A5A50003)
    `CHK(nbad, 2)
    // payload end points: 2048 dwords is legal, 2049 is malformed
    for (j = 2048; j < 2050; j++) begin
      m.send(32'h00000048, 0);
      for (i = 1; i <= j; i++) m.send(i, i == j);
      m.idle;
      repeat (2) @(posedge clk);
      #1 `CHK(nbad, j - 2046)
    end
    $display("received data frames done");
  endtask
  task t_tx_frames;
    tx_run(3'h0, 5); `CHK(m.got[0], 33'h004584034)
    tx_run(3'h1, 5); `CHK(m.got[0], 33'h004586034)
    `CHK(m.got[1], 33'h0A0789ABC)
    `CHK(m.got[2], 33'h000000000)
    `CHK(m.got[3], 33'h050000102)
    `CHK(m.got[4], 33'h100000200)
    tdev = 8'hE0;
    {tirq, tdir} = 2'h0;
    tx_run(3'h1, 5); `CHK(m.got[0], 33'h004580034)
    `CHK(m.got[2], 33'h000123456)
    {tirq, tdir} = 2'h3;
    tx_run(3'h2, 1); `CHK(m.got[0], 33'h100000039)
    tx_run(3'h3, 7); `CHK(m.got[0], 33'h000006041)
    `CHK(m.got[1], 33'h00000001F)
    `CHK(m.got[4], 33'h000000400)
    `CHK(m.got[5], 33'h000001000)
    tx_run(3'h4, 2); `CHK(m.got[1], 33'h180000001)
    pv = 1; pd = 32'hC0DE0001;
    fork
      tx_run(3'h5, 3);
      begin
        @(posedge clk); while (!ppr) @(posedge clk);
        #1 pd = 32'hC0DE0002; pl = 1;
        @(posedge clk); while (!ppr) @(posedge clk);
        #1 pv = 0;
      end
    join
    `CHK(m.got[0], 33'h000000048)
    `CHK(m.got[2], 33'h1C0DE0002)
    `CHK(nlen, 0)
    // an endless source is cut after 2048 payload dwords
    pv = 1;
    pl = 0;
    tx_run(3'h5, 2049);
    pv = 0;
    `CHK(nlen, 1)
    $display("transmitted frames done");
  endtask
  task t_pin;
    `CHK(uut.o_spinup_disabled, 1'h0)
    act = 1;
    repeat (3) @(posedge clk);
    #1 `CHK(pin, 1'h0)
    // host holds the pin low across a reset: spin-up disable is caught
    host_pull = 1;
    arst_n = 0;
    @(posedge clk);
    #1 `CHK(oe, 1'h0)
    arst_n = 1;
    @(posedge clk);
    #1 `CHK(uut.o_spinup_disabled, 1'h1)
    $display("pin duty done");
  endtask
  initial begin
    {arst_n, req, act, host_pull, pv, pl, kind, pd} = 0;
    {pay_rdy, ext} = 2'h3;
    {tdev, tlba, tcnt, txfer} = {8'hA0, 48'h123456789ABC, 16'h0102, 16'h0200};
    {tirq, tdir, ttag, tdone} = {2'h3, 5'h1F, 32'h80000001};
    repeat (3) @(posedge clk);
    #1 arst_n = 1;
    t_host_cmd;
    t_rx_data;
    t_tx_frames;
    t_pin;
    conclude;
  end
endmodule
